/* File: src/phase_channel.sv */
// One output pair of the timing unit: center-based compare with dead time and clamping.
`timescale 1ns/1ns
`default_nettype none
module phase_channel (
  timing_if.sink                          tb,
  input  wire logic [pwm_timing_pkg::TM_W-1:0] duty_i,
  output logic                            high_o,
  output logic                            low_o
);
  logic signed [pwm_timing_pkg::CALC_W-1:0] t;
  logic signed [pwm_timing_pkg::CALC_W-1:0] d;
  logic signed [pwm_timing_pkg::CALC_W-1:0] m;
  logic signed [pwm_timing_pkg::CALC_W-1:0] w;
  logic                                     hi_first;
  logic                                     lo_first;
  logic                                     hi_second;
  logic                                     lo_second;

  // Operands widened to signed so negative thresholds clamp naturally.
  assign t = $signed({2'h0, tb.cnt});
  assign d = $signed({2'h0, duty_i});
  assign m = $signed({2'h0, tb.half_period});
  assign w = $signed({8'h00, tb.dead_time});

  // First half counts toward the center: high edge late by dt, low edge early by dt.
  assign hi_first  = (t >= (m - d + w));
  assign lo_first  = (t <  (m - d - w));
  // Second half counts away from the center, mirrored.
  assign hi_second = (t <  (d - w));
  assign lo_second = (t >= (d + w));

  // Nothing switches until the timer is running.
  assign high_o = tb.run & (tb.second_half ? hi_second : hi_first);
  assign low_o  = tb.run & (tb.second_half ? lo_second : lo_first);
endmodule
`default_nettype wire

/* File: src/pwm_timing_pkg.sv */
// Constants, register map and field layout of the three-phase center-based PWM timing unit.
// Contract
// - Mode control bit 6 clear selects single update, set selects double update.
// - After reset the update mode bit is clear, so single update mode runs.
// - Single update: one sync pulse per period; its rising edge loads all timing values.
// - Output segment value is latched on the same sync rising edge as timing values.
// - Double update: second sync pulse at midpoint reloads everything for the second half.
// - Status bit 3 is clear in the first half, set in the second half.
// - Sync pulse stays high for sync width value plus one clocks.
// - Sync width register resets to 0x27, forty clocks.
// - The sync pulse is driven out to the converter subsystem.
// - Duty registers A, B, C set high-side half-period on-time of pairs A, B, C.
// - Waveforms are centered; dead time moves every edge by dead-time clocks.
// - Single update: high on 2*(duty-dt), low on 2*(tm-duty-dt) clocks.
// - On-times are clamped between zero and the full period.
// - Double update: on-time sums both halves, each with its own values.
// - Double update inserts dead time exactly as single update does.
// - No switching until half period and all three duties were written once.
// - First sync comes 1.5*tm clocks after first half period write, tm in double.
// - The unit counts in clock periods of the one instruction clock.
// - The half period value is the clock count of half a switching period.
// - An interrupt request is raised on each sync pulse, another on shutdown; this unit ties its shutdown request low.
package pwm_timing_pkg;

  // Register bus geometry.
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // Register word addresses.
  localparam logic [ADDR_W-1:0] ADDR_MODE_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_STATUS      = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_HALF_PERIOD = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_DEAD_TIME   = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_MIN_PULSE   = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_SYNC_WIDTH  = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_DUTY_A      = 4'h6;
  localparam logic [ADDR_W-1:0] ADDR_DUTY_B      = 4'h7;
  localparam logic [ADDR_W-1:0] ADDR_DUTY_C      = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_OUT_SEGMENT = 4'h9;
  localparam logic [ADDR_W-1:0] ADDR_ACT_MIN_PLS = 4'ha;

  // Field widths.
  localparam int TM_W   = 16;
  localparam int DT_W   = 10;
  localparam int SYNC_W = 8;
  localparam int SEG_W  = 9;
  localparam int CALC_W = 18;
  localparam int LEAD_W = 17;

  // Field positions.
  localparam int MODE_DOUBLE_BIT   = 6;
  localparam int STATUS_HALF_BIT   = 3;
  localparam int STATUS_RUN_BIT    = 0;
  localparam int SEG_XOVER_A_BIT   = 8;
  localparam int SEG_DIS_A_HI_BIT  = 4;

  // Reset values.
  localparam logic [DATA_W-1:0] MODE_CTRL_RESET  = 16'h0000;
  localparam logic [SYNC_W-1:0] SYNC_WIDTH_RESET = 8'h27;
  localparam logic [TM_W-1:0]   TM_RESET         = 16'h0000;
  localparam logic [DT_W-1:0]   DT_RESET         = 10'h000;
  localparam logic [SEG_W-1:0]  SEG_RESET        = 9'h000;

  // Number of output pairs.
  localparam int PHASES = 3;

endpackage

/* File: src/pwm_timing_unit.sv */
// Top of the three-phase center-based PWM timing unit with its register port.
`timescale 1ns/1ns
`default_nettype none
module pwm_timing_unit (
  input  wire logic                              ref_clk_i,
  input  wire logic                              rst_n_i,
  input  wire logic [pwm_timing_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [pwm_timing_pkg::DATA_W-1:0] wdata_i,
  input  wire logic                              wr_i,
  input  wire logic                              rd_i,
  output logic      [pwm_timing_pkg::DATA_W-1:0] rdata_o,
  output logic                                   phase_a_high_out_o,
  output logic                                   phase_a_low_out_o,
  output logic                                   phase_b_high_out_o,
  output logic                                   phase_b_low_out_o,
  output logic                                   phase_c_high_out_o,
  output logic                                   phase_c_low_out_o,
  output logic                                   period_sync_pulse_o,
  output logic                                   sync_irq_o,
  output logic                                   shutdown_irq_o
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LEAD,
    ST_RUN
  } run_state_e;

  // True when a strobe addresses the given register.
  function automatic logic hit(input logic [pwm_timing_pkg::ADDR_W-1:0] a,
                               input logic [pwm_timing_pkg::ADDR_W-1:0] r);
    hit = (a == r);
  endfunction

  logic                                rst_meta;
  logic                                rst_n;
  logic [pwm_timing_pkg::DATA_W-1:0]   mode_ctrl;
  logic [pwm_timing_pkg::TM_W-1:0]     half_period_h;
  logic [pwm_timing_pkg::DT_W-1:0]     dead_time_h;
  logic [pwm_timing_pkg::TM_W-1:0]     min_pulse_h;
  logic [pwm_timing_pkg::SYNC_W-1:0]   sync_width_h;
  logic [pwm_timing_pkg::TM_W-1:0]     duty_h [pwm_timing_pkg::PHASES];
  logic [pwm_timing_pkg::SEG_W-1:0]    seg_h;
  logic [3:0]                          written;
  logic [pwm_timing_pkg::TM_W-1:0]     tm_act;
  logic [pwm_timing_pkg::DT_W-1:0]     dt_act;
  logic [pwm_timing_pkg::TM_W-1:0]     pd_act;
  logic [pwm_timing_pkg::TM_W-1:0]     duty_act [pwm_timing_pkg::PHASES];
  logic [pwm_timing_pkg::SEG_W-1:0]    seg_act;
  run_state_e                          state;
  logic [pwm_timing_pkg::LEAD_W-1:0]   lead_cnt;
  logic [pwm_timing_pkg::TM_W-1:0]     cnt;
  logic                                second_half;
  logic [pwm_timing_pkg::PHASES-1:0]   pin_hi;
  logic [pwm_timing_pkg::PHASES-1:0]   pin_lo;
  logic [pwm_timing_pkg::PHASES-1:0]   unit_hi;
  logic [pwm_timing_pkg::PHASES-1:0]   unit_lo;
  logic [pwm_timing_pkg::DATA_W-1:0]   read_mux;
  logic                                sync_irq;

  wire logic                           double_mode;
  wire logic                           all_written;
  wire logic                           first_tm_write;
  wire logic [pwm_timing_pkg::LEAD_W-1:0] lead_value;
  wire logic                           lead_done;
  wire logic                           half_end;
  wire logic                           start_run;
  wire logic                           load_now;
  wire logic                           sync_start;

  timing_if tif ();

  // Reset is released through two flip-flops; everything below uses the copy.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Mode and start-up decoding.
  assign double_mode    = mode_ctrl[pwm_timing_pkg::MODE_DOUBLE_BIT];
  assign all_written    = &written;
  assign first_tm_write = wr_i & hit(addr_i, pwm_timing_pkg::ADDR_HALF_PERIOD) & ~written[0];
  // Lead-in before the first sync: 1.5 half periods single, one half period double.
  assign lead_value     = double_mode ? {1'b0, wdata_i}
                                      : ({1'b0, wdata_i} + {2'b00, wdata_i[15:1]});
  assign lead_done      = (lead_cnt <= 17'h00001);

  // A half ends on its last count; a zero half period ends every clock.
  assign half_end   = (({1'b0, cnt} + 17'h00001) >= {1'b0, tm_act});
  assign start_run  = (state == ST_LEAD) & lead_done & all_written;
  // Loads occur at every period start, and at the midpoint in double mode.
  assign load_now   = start_run
                    | ((state == ST_RUN) & half_end & (second_half | double_mode));
  assign sync_start = load_now;

  // Holding registers: software writes never touch the running values.
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mode_ctrl     <= pwm_timing_pkg::MODE_CTRL_RESET;
      half_period_h <= pwm_timing_pkg::TM_RESET;
      dead_time_h   <= pwm_timing_pkg::DT_RESET;
      min_pulse_h   <= pwm_timing_pkg::TM_RESET;
      sync_width_h  <= pwm_timing_pkg::SYNC_WIDTH_RESET;
      seg_h         <= pwm_timing_pkg::SEG_RESET;
      written       <= 4'h0;
      for (int p = 0; p < pwm_timing_pkg::PHASES; p++) begin
        duty_h[p] <= pwm_timing_pkg::TM_RESET;
      end
    end else if (wr_i) begin
      if (hit(addr_i, pwm_timing_pkg::ADDR_MODE_CTRL)) begin
        mode_ctrl <= wdata_i;
      end
      if (hit(addr_i, pwm_timing_pkg::ADDR_HALF_PERIOD)) begin
        half_period_h <= wdata_i;
        written[0]    <= 1'b1;
      end
      if (hit(addr_i, pwm_timing_pkg::ADDR_DEAD_TIME)) begin
        dead_time_h <= wdata_i[pwm_timing_pkg::DT_W-1:0];
      end
      if (hit(addr_i, pwm_timing_pkg::ADDR_MIN_PULSE)) begin
        min_pulse_h <= wdata_i;
      end
      if (hit(addr_i, pwm_timing_pkg::ADDR_SYNC_WIDTH)) begin
        sync_width_h <= wdata_i[pwm_timing_pkg::SYNC_W-1:0];
      end
      if (hit(addr_i, pwm_timing_pkg::ADDR_OUT_SEGMENT)) begin
        seg_h <= wdata_i[pwm_timing_pkg::SEG_W-1:0];
      end
      for (int p = 0; p < pwm_timing_pkg::PHASES; p++) begin
        if (hit(addr_i, pwm_timing_pkg::ADDR_DUTY_A + 4'(p))) begin
          duty_h[p]      <= wdata_i;
          written[p + 1] <= 1'b1;
        end
      end
    end
  end

  // Start-up sequencer: idle until the half period is written, then lead in.
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state    <= ST_IDLE;
      lead_cnt <= 17'h00000;
    end else begin
      case (state)
        ST_IDLE: begin
          if (first_tm_write) begin
            state    <= ST_LEAD;
            lead_cnt <= lead_value;
          end
        end
        ST_LEAD: begin
          if (start_run) begin
            state <= ST_RUN;
          end else if (!lead_done) begin
            lead_cnt <= lead_cnt - 17'h00001;
          end
        end
        ST_RUN: begin
          state <= ST_RUN;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Half-period counter: counts one per clock and swaps halves at each end.
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cnt         <= 16'h0000;
      second_half <= 1'b0;
    end else if (start_run) begin
      cnt         <= 16'h0000;
      second_half <= 1'b0;
    end else if (state == ST_RUN) begin
      if (half_end) begin
        cnt         <= 16'h0000;
        second_half <= ~second_half;
      end else begin
        cnt <= cnt + 16'h0001;
      end
    end
  end

  // Active values are copied from the holding registers only at load points.
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tm_act  <= pwm_timing_pkg::TM_RESET;
      dt_act  <= pwm_timing_pkg::DT_RESET;
      pd_act  <= pwm_timing_pkg::TM_RESET;
      seg_act <= pwm_timing_pkg::SEG_RESET;
      for (int p = 0; p < pwm_timing_pkg::PHASES; p++) begin
        duty_act[p] <= pwm_timing_pkg::TM_RESET;
      end
    end else if (load_now) begin
      tm_act  <= half_period_h;
      dt_act  <= dead_time_h;
      pd_act  <= min_pulse_h;
      seg_act <= seg_h;
      for (int p = 0; p < pwm_timing_pkg::PHASES; p++) begin
        duty_act[p] <= duty_h[p];
      end
    end
  end

  // Running values shared with the phase channels.
  assign tif.cnt         = cnt;
  assign tif.second_half = second_half;
  assign tif.half_period = tm_act;
  assign tif.dead_time   = dt_act;
  assign tif.run         = (state == ST_RUN);

  // The sync width used is the one loaded at the same edge.
  sync_pulse_gen u_sync (
    .clk_i   (ref_clk_i),
    .rst_n_i (rst_n),
    .start_i (sync_start),
    .width_i (sync_width_h),
    .sync_o  (period_sync_pulse_o)
  );

  // One channel per pair, then crossover and disable from the latched segment.
  for (genvar g = 0; g < pwm_timing_pkg::PHASES; g++) begin : g_phase
    localparam int XB = pwm_timing_pkg::SEG_XOVER_A_BIT - g;
    localparam int HB = pwm_timing_pkg::SEG_DIS_A_HI_BIT - 2 * g;

    wire logic steer_hi;
    wire logic steer_lo;

    phase_channel u_chan (
      .tb     (tif),
      .duty_i (duty_act[g]),
      .high_o (unit_hi[g]),
      .low_o  (unit_lo[g])
    );

    // Crossover swaps the pair; a set disable bit forces the pin off.
    assign steer_hi = seg_act[XB] ? unit_lo[g] : unit_hi[g];
    assign steer_lo = seg_act[XB] ? unit_hi[g] : unit_lo[g];

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
        pin_hi[g] <= 1'b0;
        pin_lo[g] <= 1'b0;
      end else begin
        pin_hi[g] <= steer_hi & ~seg_act[HB];
        pin_lo[g] <= steer_lo & ~seg_act[HB + 1];
      end
    end
  end

  assign phase_a_high_out_o = pin_hi[0];
  assign phase_a_low_out_o  = pin_lo[0];
  assign phase_b_high_out_o = pin_hi[1];
  assign phase_b_low_out_o  = pin_lo[1];
  assign phase_c_high_out_o = pin_hi[2];
  assign phase_c_low_out_o  = pin_lo[2];

  // Read selection; unmapped words read as zero.
  always_comb begin
    read_mux = 16'h0000;
    case (addr_i)
      pwm_timing_pkg::ADDR_MODE_CTRL:   read_mux = mode_ctrl;
      pwm_timing_pkg::ADDR_STATUS: begin
        read_mux[pwm_timing_pkg::STATUS_HALF_BIT] = second_half;
        read_mux[pwm_timing_pkg::STATUS_RUN_BIT]  = (state == ST_RUN);
      end
      pwm_timing_pkg::ADDR_HALF_PERIOD: read_mux = half_period_h;
      pwm_timing_pkg::ADDR_DEAD_TIME:   read_mux = {6'h00, dead_time_h};
      pwm_timing_pkg::ADDR_MIN_PULSE:   read_mux = min_pulse_h;
      pwm_timing_pkg::ADDR_SYNC_WIDTH:  read_mux = {8'h00, sync_width_h};
      pwm_timing_pkg::ADDR_DUTY_A:      read_mux = duty_h[0];
      pwm_timing_pkg::ADDR_DUTY_B:      read_mux = duty_h[1];
      pwm_timing_pkg::ADDR_DUTY_C:      read_mux = duty_h[2];
      pwm_timing_pkg::ADDR_OUT_SEGMENT: read_mux = {7'h00, seg_h};
      pwm_timing_pkg::ADDR_ACT_MIN_PLS: read_mux = pd_act;
      default:                          read_mux = 16'h0000;
    endcase
  end

  // Read data appears the cycle after the read strobe and only then.
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_o <= 16'h0000;
    end else if (rd_i) begin
      rdata_o <= read_mux;
    end else begin
      rdata_o <= 16'h0000;
    end
  end

  // Interrupt request: one clock at each sync start.
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sync_irq <= 1'b0;
    end else begin
      sync_irq <= sync_start;
    end
  end

  assign sync_irq_o     = sync_irq;
  // This unit holds no shutdown path, so its shutdown request stays low.
  assign shutdown_irq_o = 1'b0;

endmodule
`default_nettype wire

/* File: src/sync_pulse_gen.sv */
// Generator of the period sync pulse with programmable width.
`timescale 1ns/1ns
`default_nettype none
module sync_pulse_gen (
  input  wire logic                              clk_i,
  input  wire logic                              rst_n_i,
  input  wire logic                              start_i,
  input  wire logic [pwm_timing_pkg::SYNC_W-1:0] width_i,
  output logic                                   sync_o
);
  logic [pwm_timing_pkg::SYNC_W-1:0] remain;

  // A start restarts the pulse; it then holds for width plus one clocks.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_o <= 1'b0;
      remain <= 8'h00;
    end else if (start_i) begin
      sync_o <= 1'b1;
      remain <= width_i;
    end else if (sync_o) begin
      if (remain == 8'h00) begin
        sync_o <= 1'b0;
      end else begin
        remain <= remain - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

/* File: src/timing_if.sv */
// Interface carrying the running count and active timing values to the phase channels.
`timescale 1ns/1ns
`default_nettype none
interface timing_if;
  logic [pwm_timing_pkg::TM_W-1:0] cnt;
  logic                            second_half;
  logic [pwm_timing_pkg::TM_W-1:0] half_period;
  logic [pwm_timing_pkg::DT_W-1:0] dead_time;
  logic                            run;

  modport source (
    output cnt,
    output second_half,
    output half_period,
    output dead_time,
    output run
  );

  modport sink (
    input cnt,
    input second_half,
    input half_period,
    input dead_time,
    input run
  );
endinterface
`default_nettype wire

/* File: testbench/gate_drive_model.sv */
// Gate driver model that measures drive time of each output between sync rises.
`timescale 1ns/1ns
`default_nettype none
module gate_drive_model (
  input  wire logic        clk_i,
  input  wire logic        sync_i,
  input  wire logic [2:0]  high_i,
  input  wire logic [2:0]  low_i,
  output logic [15:0]      win_len_o,
  output logic [2:0][15:0] high_on_o,
  output logic [2:0][15:0] low_on_o,
  output logic [8:0]       sync_len_o
);
  logic [15:0]      cnt = 16'h0000;
  logic [2:0][15:0] high_acc = '0;
  logic [2:0][15:0] low_acc = '0;
  logic [8:0]       slen = 9'h000;
  logic             sync_d = 1'b0;
  logic             rise;
  assign rise = sync_i && !sync_d;
  // Sums drive cycles of each output from one sync rise to the next.
  always_ff @(posedge clk_i) begin
    sync_d <= sync_i;
    cnt <= (rise ? 16'h0000 : cnt) + 16'h0001;
    slen <= sync_i ? slen + 9'h001 : 9'h000;
    if (sync_d && !sync_i) sync_len_o <= slen;
    if (rise) begin
      win_len_o <= cnt;
      high_on_o <= high_acc;
      low_on_o <= low_acc;
    end
    for (int i = 0; i < 3; i++) begin
      high_acc[i] <= (rise ? 16'h0000 : high_acc[i]) + {15'h0000, high_i[i]};
      low_acc[i] <= (rise ? 16'h0000 : low_acc[i]) + {15'h0000, low_i[i]};
    end
  end
endmodule
`default_nettype wire

/* File: testbench/pwm_timing_unit_sva.sv */
// Checker of sync width, interrupts, read port and output pairs of the timing unit.
`timescale 1ns/1ns
`default_nettype none
module pwm_timing_unit_sva (
  input wire logic        ref_clk_i,
  input wire logic        rst_n_i,
  input wire logic [3:0]  addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic        phase_a_high_out_o,
  input wire logic        phase_a_low_out_o,
  input wire logic        phase_b_high_out_o,
  input wire logic        phase_b_low_out_o,
  input wire logic        phase_c_high_out_o,
  input wire logic        phase_c_low_out_o,
  input wire logic        period_sync_pulse_o,
  input wire logic        sync_irq_o,
  input wire logic        shutdown_irq_o
);
  logic [7:0] width_hold;
  logic [7:0] width_used;
  logic [8:0] high_cnt;
  logic [3:0] seen;
  logic       any_out;
  assign any_out = phase_a_high_out_o | phase_a_low_out_o | phase_b_high_out_o |
                   phase_b_low_out_o | phase_c_high_out_o | phase_c_low_out_o;
  // Shadows the width register, keeps the width taken at a load and times the pulse.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      width_hold <= 8'h27;
      width_used <= 8'h27;
      high_cnt   <= 9'h000;
      seen       <= 4'h0;
    end else begin
      if (wr_i && addr_i == 4'h5) width_hold <= wdata_i[7:0];
      if (!period_sync_pulse_o) width_used <= width_hold;
      if (wr_i) seen <= seen | {addr_i == 4'h8, addr_i == 4'h7, addr_i == 4'h6, addr_i == 4'h2};
      high_cnt <= period_sync_pulse_o ? high_cnt + 9'h001 : 9'h000;
    end
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_sync_width;
    $fell(period_sync_pulse_o) |-> high_cnt == {1'b0, width_used} + 9'h001;
  endproperty
  property p_irq_rise;
    $rose(period_sync_pulse_o) |-> sync_irq_o;
  endproperty
  property p_irq_only_rise;
    sync_irq_o |-> $rose(period_sync_pulse_o) ##1 !sync_irq_o;
  endproperty
  property p_no_shutdown;
    !shutdown_irq_o;
  endproperty
  property p_read_idle;
    !$past(rd_i) |-> rdata_o == 16'h0000;
  endproperty
  property p_width_read;
    $past(rd_i) && $past(addr_i) == 4'h5 |-> rdata_o == {8'h00, $past(width_hold)};
  endproperty
  property p_idle_until_config;
    seen != 4'hf |-> !any_out && !period_sync_pulse_o;
  endproperty
  property p_pair_a;
    !(phase_a_high_out_o && phase_a_low_out_o);
  endproperty
  property p_pair_b;
    !(phase_b_high_out_o && phase_b_low_out_o);
  endproperty
  property p_pair_c;
    !(phase_c_high_out_o && phase_c_low_out_o);
  endproperty
  a_sync_width: assert property (p_sync_width) else $error("sync width wrong");
  a_irq_rise: assert property (p_irq_rise) else $error("no irq at sync");
  a_irq_only_rise: assert property (p_irq_only_rise) else $error("stray irq");
  a_no_shutdown: assert property (p_no_shutdown) else $error("shutdown irq");
  a_read_idle: assert property (p_read_idle) else $error("read data not idle");
  a_width_read: assert property (p_width_read) else $error("width readback");
  a_idle_until_config: assert property (p_idle_until_config) else $error("early out");
  a_pair_a: assert property (p_pair_a) else $error("pair a overlap");
  a_pair_b: assert property (p_pair_b) else $error("pair b overlap");
  a_pair_c: assert property (p_pair_c) else $error("pair c overlap");
  c_sync: cover property ($rose(period_sync_pulse_o));
  c_fall: cover property ($fell(period_sync_pulse_o));
  c_half: cover property ($past(rd_i) && $past(addr_i) == 4'h1 && rdata_o[3]);
endmodule
bind pwm_timing_unit pwm_timing_unit_sva chk (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .phase_a_high_out_o(phase_a_high_out_o), .phase_a_low_out_o(phase_a_low_out_o),
  .phase_b_high_out_o(phase_b_high_out_o), .phase_b_low_out_o(phase_b_low_out_o),
  .phase_c_high_out_o(phase_c_high_out_o), .phase_c_low_out_o(phase_c_low_out_o),
  .period_sync_pulse_o(period_sync_pulse_o), .sync_irq_o(sync_irq_o),
  .shutdown_irq_o(shutdown_irq_o));
`default_nettype wire

/* File: testbench/tb_three_phase_center_pwm_timing.sv */
// Self-checking testbench of the three-phase center-based PWM timing unit.
`timescale 1ns/1ns
`default_nettype none
module tb_three_phase_center_pwm_timing;
  logic ref_clk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000, rdata_o, got, win_len;
  logic [2:0] hi, lo;
  logic sync;
  logic [2:0][15:0] hi_on, lo_on;
  logic [8:0] sync_len;
  int failures = 0, n_tests = 0, cycles = 0, seed = 32'h3c84;
  int tm, dt, dt2, w, c, d[3], da[3], db[3], hs[3], ls[3];
  pwm_timing_unit DUT (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .phase_a_high_out_o(hi[0]), .phase_a_low_out_o(lo[0]), .phase_b_high_out_o(hi[1]),
    .phase_b_low_out_o(lo[1]), .phase_c_high_out_o(hi[2]), .phase_c_low_out_o(lo[2]),
    .period_sync_pulse_o(sync), .sync_irq_o(), .shutdown_irq_o());
  gate_drive_model drv (.clk_i(ref_clk_i), .sync_i(sync), .high_i(hi), .low_i(lo),
    .win_len_o(win_len), .high_on_o(hi_on), .low_on_o(lo_on), .sync_len_o(sync_len));
  // Clock of 40 ns and a cycle limit against hangs.
  initial forever #20 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] g, input logic [15:0] e, input string m);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input int v);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= v[15:0];
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    @(negedge ref_clk_i);
    got = rdata_o;
  endtask
  // Waits for a sync rise and lets the model latch its window.
  task automatic wait_sync();
    int k;
    k = 0;
    while (sync === 1'b1 && k < 2000) begin @(posedge ref_clk_i); k++; end
    while (sync !== 1'b1 && k < 2000) begin @(posedge ref_clk_i); k++; end
    check(16'(k < 2000), 16'h0001, "sync missing");
    #1;
  endtask
  function automatic logic [15:0] clamp(input int x, input int top);
    return (x < 0) ? 16'h0000 : (x > top) ? 16'(top) : 16'(x);
  endfunction
  initial begin
    repeat (20) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    rd(4'h5); check(got, 16'h0027, "width reset");
    rd(4'h0); check({15'h0000, got[6]}, 16'h0000, "mode reset");
    rd(4'hb); check(got, 16'h0000, "unmapped read");
    $display("test reset values done");
    tm = 200;
    dt = 1 + {$random(seed)} % 8;
    w = {$random(seed)} % 60;
    d[0] = dt + {$random(seed)} % (tm - 2 * dt);
    d[1] = dt - 1;
    d[2] = tm + dt + 3;
    wr(4'h3, dt);
    wr(4'h5, w);
    wr(4'h2, tm);
    c = 0;
    fork
      while (sync !== 1'b1 && c < 1000) begin @(posedge ref_clk_i); c++; end
      begin
        repeat (50) @(posedge ref_clk_i);
        check({13'h0000, hi | lo}, 16'h0000, "idle outputs");
        for (int i = 0; i < 3; i++) wr(4'h6 + 4'(i), d[i]);
      end
    join
    check(16'(c >= tm * 3 / 2 && c <= tm * 3 / 2 + 2), 16'h0001, "first sync");
    $display("test start of switching done");
    repeat (3) wait_sync();
    check(win_len, 16'(2 * tm), "single period");
    check({7'h00, sync_len}, 16'(w + 1), "sync width");
    for (int i = 0; i < 3; i++) begin
      check(hi_on[i], clamp(2 * (d[i] - dt), 2 * tm), "high on");
      check(lo_on[i], clamp(2 * (tm - d[i] - dt), 2 * tm), "low on");
    end
    rd(4'h1); check({15'h0000, got[3]}, 16'h0000, "first half");
    repeat (tm) @(posedge ref_clk_i);
    rd(4'h1); check({15'h0000, got[3]}, 16'h0001, "second half");
    $display("test single update done");
    dt2 = 1 + {$random(seed)} % 8;
    for (int i = 0; i < 3; i++) begin
      da[i] = 10 + {$random(seed)} % 180;
      db[i] = 10 + {$random(seed)} % 180;
      hs[i] = 0;
      ls[i] = 0;
    end
    wr(4'h0, 16'h0040);
    for (int n = 0; n < 6; n++) begin
      wait_sync();
      if (n >= 4) begin
        check(win_len, 16'(tm), "half window");
        for (int i = 0; i < 3; i++) begin
          hs[i] += hi_on[i];
          ls[i] += lo_on[i];
        end
      end
      rd(4'h1);
      wr(4'h3, got[3] ? dt : dt2);
      for (int i = 0; i < 3; i++) wr(4'h6 + 4'(i), got[3] ? da[i] : db[i]);
    end
    for (int i = 0; i < 3; i++) begin
      check(16'(hs[i]), 16'(da[i] + db[i] - dt - dt2), "double high");
      check(16'(ls[i]), 16'(2 * tm - da[i] - db[i] - dt - dt2), "double low");
    end
    wr(4'h9, 16'h003f);
    repeat (3) wait_sync();
    check(hi_on[0] | lo_on[1] | hi_on[2], 16'h0000, "segment off");
    $display("test double update done");
    complete_run();
  end
endmodule
`default_nettype wire
